/* File: hw/pmc_pkg.sv */
// package for the port pin mode control block
`default_nettype none
package pmc_pkg;
    // ==========================================================
    // geometry
    localparam int NPORT = 4; // ports 1..4 at index 0..3
    localparam int PW = 8; // pins per port
    localparam int NPIN = 32; // all pins, index = port * 8 + bit
    // ==========================================================
    // special function register addresses, index 0 is port 1
    localparam logic [3:0][7:0] LAT_ADDR = {8'hC0, 8'hB0, 8'hA0, 8'h90};
    localparam logic [3:0][7:0] MODE_A_ADDR = {8'hBE, 8'hC6, 8'hC4, 8'hC2};
    localparam logic [3:0][7:0] MODE_B_ADDR = {8'hBF, 8'hC7, 8'hC5, 8'hC3};
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // ==========================================================
    // pin modes, code is {mode_select_bit_a, mode_select_bit_b}
    localparam logic [1:0] MODE_QUASI = 2'h0;
    localparam logic [1:0] MODE_PUSH = 2'h1;
    localparam logic [1:0] MODE_INPUT = 2'h2;
    localparam logic [1:0] MODE_OPEN = 2'h3;
    // ==========================================================
    // reset values
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] MODE_A_QUASI_RST = 8'h00;
    localparam logic [7:0] MODE_A_TRI_RST = 8'hFF;
    localparam logic [7:0] MODE_B_RST = 8'h00;
    localparam int ANALOG_PORT = 1; // port 2
    localparam logic [7:0] ANALOG_MASK = 8'hF0; // bits 4..7 of port 2
    // ==========================================================
    // power-down wake pins: port 3 bits 2, 3, 6 and port 4 bits 0, 1
    localparam logic [31:0] WAKE_PIN_MASK = 32'h034C_0000;
    localparam logic [31:0] BUF_ALL_ON = 32'hFFFF_FFFF;
    // ==========================================================
    // timing: strong pull-up length in core clocks
    localparam logic [1:0] STRONG_PU_CYCLES = 2'h2;
    localparam logic [1:0] CNT_ZERO = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic wr; // write strobe
        logic rd; // read strobe
        logic rmw; // read for read-modify-write
        logic [7:0] addr; // register address
        logic [7:0] wdata; // write data
    } pmc_sfr_req_s;
    typedef struct packed {
        logic [31:0] pull_dn; // strong pull-down
        logic [31:0] pu_vweak; // very weak pull-up
        logic [31:0] pu_weak; // weak pull-up
        logic [31:0] pu_strong; // strong pull-up
    } pmc_drive_s;
endpackage : pmc_pkg
`default_nettype wire

/* File: hw/pmc_port_ctrl.sv */
// per-pin output mode control for four byte-wide ports
// ==========================================================
// Behaviour
// - two mode bits pick each pin's mode
// - fuse enabled: every pin input-only after reset
// - fuse off: quasi mode, analog pins input-only
// - power-down disables inputs except wake pins
// - port 1 wake inputs stay alive
// - quasi: very weak pull-up follows latch one
// - quasi: weak pull-up needs latch and pin high
// - quasi: rising latch gives two-clock strong pull-up
// - quasi: latch zero pulls down, no pull-ups
// - input-only: no pulls at all
// - open-drain: pull-down only on latch zero
// - push-pull: strong pull-up on latch one
// - plain reads see pins, rmw sees latch
// - alternate functions ANDed with latch bit
`default_nettype none
module pmc_port_ctrl (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // register access from the core
    input wire pmc_pkg::pmc_sfr_req_s sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    // system state
    input wire logic tristate_fuse_i,
    input wire logic power_down_i,
    input wire logic [7:0] wake_input_en_i,
    // pins
    input wire logic [31:0] pin_i,
    output pmc_pkg::pmc_drive_s drive_o,
    output logic [31:0] in_buf_en_o,
    // alternate functions
    input wire logic [31:0] alt_out_i,
    output logic [31:0] alt_out_o,
    output logic [31:0] alt_in_o
);
    // ==========================================================
    // storage
    logic [3:0][7:0] lat_q; // output latches
    logic [3:0][7:0] mode_a_q; // mode_select_bit_a per pin
    logic [3:0][7:0] mode_b_q; // mode_select_bit_b per pin
    logic [31:0] lat_flat; // latches as one vector
    logic [31:0] mode_a_flat; // bit a as one vector
    logic [31:0] mode_b_flat; // bit b as one vector
    logic [31:0] pin_meta_q; // first synchroniser stage
    logic [31:0] pin_sync_q; // second synchroniser stage
    logic [31:0] pin_seen; // sensed level behind input buffer
    logic [31:0] wake_keep; // buffers kept alive in power-down
    logic [7:0] rdata_d; // read mux
    logic [7:0] rdata_q; // read data register

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    assign lat_flat = lat_q;
    assign mode_a_flat = mode_a_q;
    assign mode_b_flat = mode_b_q;

    // ==========================================================
    // pin synchroniser
    // two-flop sampling
    always_ff @(posedge core_clk_i)
    begin
        pin_meta_q <= pin_i;
        pin_sync_q <= pin_meta_q;
    end

    // ==========================================================
    // input buffers
    // wake pins survive power-down
    // enabled port 1 wake inputs survive too
    // a floating wake input burns current; software must disable it
    assign wake_keep = pmc_pkg::WAKE_PIN_MASK | {24'h00_0000, wake_input_en_i};
    assign in_buf_en_o = power_down_i ? wake_keep : pmc_pkg::BUF_ALL_ON;
    // a disabled buffer reads as zero
    assign pin_seen = pin_sync_q & in_buf_en_o;

    // ==========================================================
    // per-port registers
    for (genvar p = 0; p < pmc_pkg::NPORT; p++)
    begin : g_port
        // latch write
        always_ff @(posedge core_clk_i)
        begin
            if (!resetn_i)
            begin
                lat_q[p] <= pmc_pkg::LATCH_RESET;
            end
            else if (sfr_req_i.wr && sfr_req_i.addr == pmc_pkg::LAT_ADDR[p])
            begin
                lat_q[p] <= sfr_req_i.wdata;
            end
        end
        // mode bit a: fuse picks the default, analog pins forced input
        always_ff @(posedge core_clk_i)
        begin
            if (!resetn_i)
            begin
                if (tristate_fuse_i)
                begin
                    mode_a_q[p] <= pmc_pkg::MODE_A_TRI_RST;
                end
                else if (p == pmc_pkg::ANALOG_PORT)
                begin
                    mode_a_q[p] <= pmc_pkg::ANALOG_MASK;
                end
                else
                begin
                    mode_a_q[p] <= pmc_pkg::MODE_A_QUASI_RST;
                end
            end
            else if (sfr_req_i.wr && sfr_req_i.addr == pmc_pkg::MODE_A_ADDR[p])
            begin
                mode_a_q[p] <= sfr_req_i.wdata;
            end
        end
        // mode bit b resets to zero in both defaults
        always_ff @(posedge core_clk_i)
        begin
            if (!resetn_i)
            begin
                mode_b_q[p] <= pmc_pkg::MODE_B_RST;
            end
            else if (sfr_req_i.wr && sfr_req_i.addr == pmc_pkg::MODE_B_ADDR[p])
            begin
                mode_b_q[p] <= sfr_req_i.wdata;
            end
        end
    end

    // ==========================================================
    // read path
    // plain read sees pins, rmw sees latch
    always_comb
    begin
        rdata_d = pmc_pkg::RDATA_UNMAPPED;
        for (int p = 0; p < pmc_pkg::NPORT; p++)
        begin
            if (sfr_req_i.addr == pmc_pkg::LAT_ADDR[p])
            begin
                rdata_d = sfr_req_i.rmw ? lat_q[p] : pin_seen[p * pmc_pkg::PW +: pmc_pkg::PW];
            end
            else if (sfr_req_i.addr == pmc_pkg::MODE_A_ADDR[p])
            begin
                rdata_d = mode_a_q[p];
            end
            else if (sfr_req_i.addr == pmc_pkg::MODE_B_ADDR[p])
            begin
                rdata_d = mode_b_q[p];
            end
        end
    end

    // read data holds until the next read
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            rdata_q <= pmc_pkg::RDATA_UNMAPPED;
        end
        else if (sfr_req_i.rd)
        begin
            rdata_q <= rdata_d;
        end
    end
    assign sfr_rdata_o = rdata_q;

    // ==========================================================
    // alternate functions
    // latch zero forces function to zero
    assign alt_out_o = alt_out_i & lat_flat;
    assign alt_in_o = pin_seen & lat_flat;

    // ==========================================================
    // per-pin drivers
    for (genvar i = 0; i < pmc_pkg::NPIN; i++)
    begin : g_pin
        logic [1:0] mode; // decoded mode code
        logic quasi; // quasi-bidirectional
        logic push; // push-pull
        logic inp; // input-only
        logic open; // open-drain
        logic lat_prev_q; // latch one cycle ago
        logic rise; // latch went 0 to 1 this cycle
        logic [1:0] cnt_q; // strong pull-up cycles left after the rise cycle, this one included

        assign mode = {mode_a_flat[i], mode_b_flat[i]};
        assign quasi = mode == pmc_pkg::MODE_QUASI;
        assign push = mode == pmc_pkg::MODE_PUSH;
        assign inp = mode == pmc_pkg::MODE_INPUT;
        assign open = mode == pmc_pkg::MODE_OPEN;
        assign rise = lat_flat[i] && !lat_prev_q;

        // previous latch value for edge detect
        always_ff @(posedge core_clk_i)
        begin
            if (!resetn_i)
            begin
                lat_prev_q <= pmc_pkg::LATCH_RESET[i % pmc_pkg::PW];
            end
            else
            begin
                lat_prev_q <= lat_flat[i];
            end
        end

        always_ff @(posedge core_clk_i)
        begin
            if (!resetn_i)
            begin
                cnt_q <= pmc_pkg::CNT_ZERO;
            end
            else if (quasi && rise)
            begin
                cnt_q <= pmc_pkg::STRONG_PU_CYCLES - pmc_pkg::CNT_ONE;
            end
            else if (cnt_q != pmc_pkg::CNT_ZERO)
            begin
                cnt_q <= cnt_q - pmc_pkg::CNT_ONE;
            end
        end

        // pull-down on latch zero unless input-only
        assign drive_o.pull_dn[i] = !lat_flat[i] && !inp;
        assign drive_o.pu_vweak[i] = quasi && lat_flat[i];
        // weak pull-up drops when pin pulled low
        assign drive_o.pu_weak[i] = quasi && lat_flat[i] && pin_sync_q[i];
        // strong pull-up: pulse in quasi, level in push-pull
        assign drive_o.pu_strong[i] = lat_flat[i]
            && (push || (quasi && (rise || cnt_q != pmc_pkg::CNT_ZERO)));

        // checks on the drivers of this pin
        sequence s_rise;
            quasi && rise;
        endsequence
        sequence s_two_strong;
            drive_o.pu_strong[i] ##1 drive_o.pu_strong[i];
        endsequence
        property p_input_off;
            inp |-> !(drive_o.pull_dn[i] || drive_o.pu_vweak[i]
                || drive_o.pu_weak[i] || drive_o.pu_strong[i]);
        endproperty
        a_input_off: assert property (p_input_off) else $error("pull on input-only pin");
        property p_quasi_low;
            quasi && !lat_flat[i] |-> drive_o.pull_dn[i] && !drive_o.pu_vweak[i]
                && !drive_o.pu_weak[i] && !drive_o.pu_strong[i];
        endproperty
        a_quasi_low: assert property (p_quasi_low) else $error("quasi low drive wrong");
        property p_open;
            open |-> drive_o.pull_dn[i] == !lat_flat[i]
                && !(drive_o.pu_vweak[i] || drive_o.pu_weak[i] || drive_o.pu_strong[i]);
        endproperty
        a_open: assert property (p_open) else $error("open-drain drive wrong");
        property p_push;
            push |-> drive_o.pu_strong[i] == lat_flat[i] && drive_o.pull_dn[i] == !lat_flat[i];
        endproperty
        a_push: assert property (p_push) else $error("push-pull drive wrong");
        property p_vweak;
            quasi |-> drive_o.pu_vweak[i] == lat_flat[i];
        endproperty
        a_vweak: assert property (p_vweak) else $error("very weak pull-up wrong");
        property p_weak;
            quasi |-> drive_o.pu_weak[i] == (lat_flat[i] && pin_sync_q[i]);
        endproperty
        a_weak: assert property (p_weak) else $error("weak pull-up wrong");
        property p_strong_start;
            s_rise |-> drive_o.pu_strong[i] ##1 (drive_o.pu_strong[i] || !quasi || !lat_flat[i]);
        endproperty
        a_strong_start: assert property (p_strong_start) else $error("strong pulse short");
        property p_strong_end;
            quasi ##0 s_two_strong |=> !drive_o.pu_strong[i] || push;
        endproperty
        a_strong_end: assert property (p_strong_end) else $error("strong pulse long");
        property p_alt_gate;
            !lat_flat[i] |-> !alt_out_o[i] && !alt_in_o[i];
        endproperty
        a_alt_gate: assert property (p_alt_gate) else $error("alternate not gated");
    end

    // ==========================================================
    // block-level checks
    property p_pd_buf;
        power_down_i |-> (in_buf_en_o & ~pmc_pkg::WAKE_PIN_MASK) == {24'h00_0000, wake_input_en_i};
    endproperty
    a_pd_buf: assert property (p_pd_buf) else $error("power-down buffer wrong");
    property p_port1_wake;
        power_down_i |-> in_buf_en_o[7:0] == wake_input_en_i;
    endproperty
    a_port1_wake: assert property (p_port1_wake) else $error("wake input dropped");
    property p_reset_tri;
        $rose(resetn_i) && $past(tristate_fuse_i)
            |-> mode_a_flat == '1 && mode_b_flat == '0;
    endproperty
    a_reset_tri: assert property (p_reset_tri) else $error("fuse default wrong");
    property p_reset_quasi;
        $rose(resetn_i) && !$past(tristate_fuse_i) |-> mode_b_flat == '0
            && mode_a_flat == {16'h0000, pmc_pkg::ANALOG_MASK, 8'h00} && lat_flat == '1;
    endproperty
    a_reset_quasi: assert property (p_reset_quasi) else $error("quasi default wrong");
    property p_read_pin;
        sfr_req_i.rd && !sfr_req_i.rmw && sfr_req_i.addr == pmc_pkg::LAT_ADDR[0]
            |=> sfr_rdata_o == $past(pin_seen[7:0]);
    endproperty
    a_read_pin: assert property (p_read_pin) else $error("plain read wrong");
    property p_read_lat;
        sfr_req_i.rd && sfr_req_i.rmw && sfr_req_i.addr == pmc_pkg::LAT_ADDR[0]
            |=> sfr_rdata_o == $past(lat_q[0]);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("rmw read wrong");
    property p_sync;
        resetn_i [*2] |-> pin_sync_q == $past(pin_i, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser depth wrong");
endmodule : pmc_port_ctrl
`default_nettype wire

/* File: verif/pmc_pin_model.sv */
// behavioural model of the board circuitry on the port pins
`default_nettype none
module pmc_pin_model (
    // clock
    input wire logic core_clk_i,
    // pulls from the block and from the board
    input wire pmc_pkg::pmc_drive_s drive_i,
    input wire logic [31:0] ext_low_i,
    input wire logic [31:0] ext_high_i,
    // resolved pin levels
    output logic [31:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // state
    logic [31:0] float_q; // level of an undriven pin
    logic [31:0] up_d; // any pull-up active
    initial float_q = 32'h0;
    // floating pins wander each cycle so a stale read never passes
    // plain always: the initial value above would be a second writer of an always_ff variable
    always @(posedge core_clk_i)
    begin
        float_q <= ~float_q;
    end
    assign up_d = drive_i.pu_vweak | drive_i.pu_weak | drive_i.pu_strong | ext_high_i;
    // sinks beat pull-ups, pull-ups beat a floating pin
    assign pin_o = ~(drive_i.pull_dn | ext_low_i) & (up_d | float_q);
endmodule : pmc_pin_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking testbench for the port pin mode control block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic core_clk_i, resetn_i, fuse, pdown;
    logic [7:0] wake_en, rdata;
    pmc_pkg::pmc_sfr_req_s req;
    pmc_pkg::pmc_drive_s drv;
    logic [31:0] pin, buf_en, alt_out, alt_o, alt_in, ext_low, ext_high;
    int n_errors, n_compared, cyc;
    // ==========================================================
    // design and pins
    pmc_port_ctrl DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .sfr_req_i(req), .sfr_rdata_o(rdata), .tristate_fuse_i(fuse),
        .power_down_i(pdown), .wake_input_en_i(wake_en), .pin_i(pin),
        .drive_o(drv), .in_buf_en_o(buf_en), .alt_out_i(alt_out),
        .alt_out_o(alt_o), .alt_in_o(alt_in));
    pmc_pin_model board (.core_clk_i(core_clk_i), .drive_i(drv),
        .ext_low_i(ext_low), .ext_high_i(ext_high), .pin_o(pin));
    // 200 MHz clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // hang guard, a full run needs well under 300 cycles
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            $display("[FAIL] %0t run timed out", $time);
            results();
        end
    end
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    // one-cycle write strobe, effective at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge core_clk_i);
        req.wr = 1'b0;
    endtask : wr
    // read strobe, data is registered one cycle later
    task automatic rdc(input logic [7:0] a, input logic m, input logic [7:0] exp);
        @(negedge core_clk_i);
        req.rd = 1'b1;
        req.rmw = m;
        req.addr = a;
        @(negedge core_clk_i);
        req.rd = 1'b0;
        req.rmw = 1'b0;
        chk({24'h0, rdata}, {24'h0, exp}, "read data");
    endtask : rdc
    // fuse must stand while reset is held, it is sampled then
    task automatic do_reset(input logic f);
        @(negedge core_clk_i);
        resetn_i = 1'b0;
        fuse = f;
        repeat (10) @(negedge core_clk_i);
        resetn_i = 1'b1;
    endtask : do_reset
    task automatic results();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    // ==========================================================
    // main sequence
    initial
    begin
        {resetn_i, fuse, pdown, wake_en, ext_low, ext_high, alt_out} = '0;
        req = '0;
        n_errors = 0;
        n_compared = 0;
        cyc = 0;
        do_reset(1'b0);
        rdc(pmc_pkg::MODE_A_ADDR[1], 1'b0, 8'hF0);
        rdc(pmc_pkg::MODE_A_ADDR[0], 1'b0, 8'h00);
        rdc(pmc_pkg::LAT_ADDR[0], 1'b1, 8'hFF);
        chk(drv.pu_vweak, 32'hFFFF_0FFF, "vweak after reset");
        // pins 0,1 quasi, 2,3 push, 4,5 input, 6,7 open, latch AA
        ext_high = 32'h0000_00B0;
        wr(pmc_pkg::MODE_A_ADDR[0], 8'hF0);
        wr(pmc_pkg::MODE_B_ADDR[0], 8'hCC);
        wr(pmc_pkg::LAT_ADDR[0], 8'hAA);
        repeat (3) @(negedge core_clk_i);
        chk(drv.pull_dn[7:0], 8'h45, "pull-down");
        chk(drv.pu_vweak[7:0], 8'h02, "very weak");
        chk(drv.pu_strong[7:0], 8'h08, "strong");
        chk(drv.pu_weak[7:0], 8'h02, "weak");
        rdc(pmc_pkg::LAT_ADDR[0], 1'b0, 8'hBA);
        // board sinks the quasi pin that outputs one
        ext_low = 32'h0000_0002;
        repeat (3) @(negedge core_clk_i);
        chk(drv.pu_weak[7:0], 8'h00, "weak off");
        chk(drv.pu_vweak[7:0], 8'h02, "vweak stays");
        rdc(pmc_pkg::LAT_ADDR[0], 1'b0, 8'hB8);
        rdc(pmc_pkg::LAT_ADDR[0], 1'b1, 8'hAA);
        // quasi pin 0 rises: strong pull-up for two clocks
        wr(pmc_pkg::LAT_ADDR[0], 8'hAB);
        chk(drv.pu_strong[7:0], 8'h09, "pulse first");
        @(negedge core_clk_i);
        chk(drv.pu_strong[7:0], 8'h09, "pulse second");
        @(negedge core_clk_i);
        chk(drv.pu_strong[7:0], 8'h08, "pulse over");
        alt_out = 32'hFFFF_FFFF;
        repeat (2) @(negedge core_clk_i);
        chk(alt_o[7:0], 8'hAB, "alt out");
        chk(alt_in[7:0], 8'hA9, "alt in");
        // wake input only on pin 0, which its own quasi pull-ups keep high
        wake_en = 8'h01;
        pdown = 1'b1;
        @(negedge core_clk_i);
        chk(buf_en, pmc_pkg::WAKE_PIN_MASK | 32'h1, "power-down");
        rdc(pmc_pkg::LAT_ADDR[0], 1'b0, 8'h01);
        pdown = 1'b0;
        wake_en = 8'h00;
        @(negedge core_clk_i);
        chk(buf_en, pmc_pkg::BUF_ALL_ON, "awake");
        // unmapped place ignores writes and reads zero
        wr(8'h91, 8'h55);
        rdc(8'h91, 1'b0, pmc_pkg::RDATA_UNMAPPED);
        for (int p = 0; p < pmc_pkg::NPORT; p++)
        begin
            wr(pmc_pkg::MODE_B_ADDR[p], 8'h3C);
            rdc(pmc_pkg::MODE_B_ADDR[p], 1'b0, 8'h3C);
            wr(pmc_pkg::LAT_ADDR[p], 8'h5A);
            rdc(pmc_pkg::LAT_ADDR[p], 1'b1, 8'h5A);
        end
        // fuse enabled: everything input-only, no pull-down, very weak or strong pull-up
        do_reset(1'b1);
        chk(drv.pull_dn | drv.pu_vweak | drv.pu_strong, 32'h0, "tristate");
        for (int p = 0; p < pmc_pkg::NPORT; p++)
            rdc(pmc_pkg::MODE_A_ADDR[p], 1'b0, 8'hFF);
        results();
    end
endmodule : tb_top
`default_nettype wire
